// File: logic/rid_core.v
// Purpose: Decode and execute of the 14-bit instruction set
// Assumes: Program and file memories answer one clock after their address
// Notes:   One instruction cycle is four ref_clk cycles
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "rid_defines.vh"

module rid_core (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata_ff,
	output reg         avs_waitrequest_ff,
	// Program memory
	output reg  [10:0] pmem_addr_ff,
	input  wire [13:0] pmem_data,
	// Data file space
	output reg  [6:0]  file_addr_ff,
	output reg  [7:0]  file_wdata_ff,
	output reg         file_we_ff,
	input  wire [7:0]  file_rdata,
	// Port pins, timer and power
	input  wire [7:0]  port_pins,
	input  wire        wake_pin,
	output reg         presc_clr_ff,
	output reg         sleep_ff,
	output reg         wdt_clr_ff,
	// Core state
	output reg  [7:0]  acc_ff,
	output reg  [4:0]  status_ff
);

	// ****************************************
	// Helpers
	// ****************************************
	// Returns {carry, digit carry, sum}
	function [9:0] addc;
		input [7:0] a;
		input [7:0] b;
		input       cin;
		reg   [4:0] lo;
		reg   [4:0] hi;
		begin
			lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			hi   = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
			addc = {hi[4], lo[4], hi[3:0], lo[3:0]};
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg [1:0]  ctrl_ff;
	reg [1:0]  ph_ff;
	reg [13:0] ir_ff;
	reg [7:0]  pin_s1_ff;
	reg [7:0]  pin_s2_ff;
	reg        wake_s1_ff;
	reg        wake_s2_ff;
	wire [10:0] stk_top;

	wire       step = ctrl_ff[`RID_CTRL_RUN] & ~sleep_ff;
	wire       exec = step & (ph_ff == `RID_PH_LAST);
	wire [1:0] cls  = ir_ff[13:12];
	wire [3:0] op   = ir_ff[11:8];
	wire       dst  = ir_ff[7];
	wire [2:0] bsel = ir_ff[9:7];
	wire [7:0] lit  = ir_ff[7:0];
	// I/O port operand comes from the pins, not the latch
	wire [7:0] opnd = (ir_ff[6:0] == `RID_PORT_B_ADDR) ? pin_s2_ff : file_rdata; // [RL14]

	// ****************************************
	// Decode
	// ****************************************
	reg [7:0]  nxt_res;
	reg        nxt_to_acc;
	reg        nxt_to_file;
	reg        nxt_z_upd;
	reg        nxt_c_upd;
	reg        nxt_dc_upd;
	reg        nxt_c;
	reg        nxt_dc;
	reg        nxt_skip;
	reg        nxt_jump;
	reg [10:0] nxt_target;
	reg        nxt_push;
	reg        nxt_pop;
	reg        nxt_sleep;
	reg        nxt_wdt;
	reg [9:0]  sum;

	always @* begin
		nxt_res     = 8'h00;
		nxt_to_acc  = 1'b0;
		nxt_to_file = 1'b0;
		nxt_z_upd   = 1'b0;
		nxt_c_upd   = 1'b0;
		nxt_dc_upd  = 1'b0;
		nxt_c       = status_ff[`RID_ST_C];
		nxt_dc      = status_ff[`RID_ST_DC];
		nxt_skip    = 1'b0;
		nxt_jump    = 1'b0;
		nxt_target  = ir_ff[10:0];
		nxt_push    = 1'b0;
		nxt_pop     = 1'b0;
		nxt_sleep   = 1'b0;
		nxt_wdt     = 1'b0;
		sum         = 10'h000;
		case (cls)
		`RID_CL_BYTE: begin
			nxt_to_acc  = ~dst; // [RL21]
			nxt_to_file = dst; // [RL21]
			nxt_z_upd   = 1'b1;
			case (op)
			`RID_OP_MISC: begin
				nxt_z_upd = 1'b0;
				nxt_to_acc = 1'b0;
				nxt_res = acc_ff;
				if (ir_ff == `RID_W_RET || ir_ff == `RID_W_RETI) begin
					nxt_jump   = 1'b1;
					nxt_pop    = 1'b1;
					nxt_target = stk_top;
				end
				nxt_sleep = (ir_ff == `RID_W_SLEEP); // [RL13]
				nxt_wdt   = (ir_ff == `RID_W_CLRWDT);
			end
			`RID_OP_CLR:   nxt_res = 8'h00;
			`RID_OP_SUB, `RID_OP_ADD: begin
				sum = (op == `RID_OP_ADD) ? addc(opnd, acc_ff, 1'b0) : addc(opnd, ~acc_ff, 1'b1); // [RL22]
				nxt_res    = sum[7:0];
				nxt_c      = sum[9];
				nxt_dc     = sum[8];
				nxt_c_upd  = 1'b1;
				nxt_dc_upd = 1'b1;
			end
			`RID_OP_DEC:   nxt_res = opnd - 8'h01;
			`RID_OP_IOR:   nxt_res = opnd | acc_ff; // [RL1]
			`RID_OP_AND:   nxt_res = opnd & acc_ff; // [RL1]
			`RID_OP_XOR:   nxt_res = opnd ^ acc_ff; // [RL1] [RL2]
			`RID_OP_MOV:   nxt_res = opnd;
			`RID_OP_COM:   nxt_res = ~opnd;
			`RID_OP_INC:   nxt_res = opnd + 8'h01;
			`RID_OP_DECSZ: begin
				nxt_res   = opnd - 8'h01;
				nxt_z_upd = 1'b0;
				nxt_skip  = (nxt_res == 8'h00); // [RL3]
			end
			`RID_OP_INCSZ: begin
				nxt_res   = opnd + 8'h01;
				nxt_z_upd = 1'b0;
				nxt_skip  = (nxt_res == 8'h00); // [RL4]
			end
			`RID_OP_RRC: begin
				nxt_res   = {status_ff[`RID_ST_C], opnd[7:1]}; // [RL6]
				nxt_c     = opnd[0];
				nxt_c_upd = 1'b1;
				nxt_z_upd = 1'b0;
			end
			`RID_OP_RLC: begin
				nxt_res   = {opnd[6:0], status_ff[`RID_ST_C]}; // [RL5]
				nxt_c     = opnd[7];
				nxt_c_upd = 1'b1;
				nxt_z_upd = 1'b0;
			end
			default: begin
				nxt_res   = {opnd[3:0], opnd[7:4]};
				nxt_z_upd = 1'b0;
			end
			endcase
			// Clear with destination bit clear writes the accumulator; move-to-file has no accumulator variant
			if (op == `RID_OP_CLR && !dst) begin
				nxt_to_acc = 1'b1;
			end
		end
		`RID_CL_BIT: begin
			nxt_res = opnd;
			case (ir_ff[11:10])
			`RID_BIT_CLR: begin
				nxt_res[bsel] = 1'b0; // [RL18]
				nxt_to_file   = 1'b1;
			end
			`RID_BIT_SET: begin
				nxt_res[bsel] = 1'b1; // [RL19]
				nxt_to_file   = 1'b1;
			end
			`RID_BIT_TSC: nxt_skip = ~opnd[bsel]; // [RL7]
			default:      nxt_skip = opnd[bsel]; // [RL8]
			endcase
		end
		`RID_CL_CTL: begin
			nxt_jump = 1'b1; // [RL20]
			nxt_push = ~ir_ff[11]; // [RL20]
		end
		default: begin
			nxt_to_acc = 1'b1;
			nxt_z_upd  = 1'b1;
			if (ir_ff[11:10] == `RID_LIT_MOV) begin
				nxt_res   = lit;
				nxt_z_upd = 1'b0;
			end else if (ir_ff[11:10] == `RID_LIT_RET) begin
				nxt_res    = lit; // [RL12]
				nxt_z_upd  = 1'b0;
				nxt_jump   = 1'b1;
				nxt_pop    = 1'b1;
				nxt_target = stk_top;
			end else if (op == `RID_LIT_IOR) begin
				nxt_res = lit | acc_ff; // [RL9]
			end else if (op == `RID_LIT_AND) begin
				nxt_res = lit & acc_ff; // [RL9]
			end else if (op == `RID_LIT_XOR) begin
				nxt_res = lit ^ acc_ff; // [RL9] [RL10]
			end else if (ir_ff[11:9] == `RID_LIT_SUB || ir_ff[11:9] == `RID_LIT_ADD) begin
				sum = (ir_ff[11:9] == `RID_LIT_ADD) ? addc(lit, acc_ff, 1'b0) : addc(lit, ~acc_ff, 1'b1); // [RL11]
				nxt_res    = sum[7:0];
				nxt_c      = sum[9];
				nxt_dc     = sum[8];
				nxt_c_upd  = 1'b1;
				nxt_dc_upd = 1'b1;
			end else begin
				// Unused literal code behaves as no-operation
				nxt_to_acc = 1'b0;
				nxt_z_upd  = 1'b0;
			end
		end
		endcase
	end

	// ****************************************
	// Return stack
	// ****************************************
	rid_stack u_stack (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.push       (exec & nxt_push),
		.pop        (exec & nxt_pop),
		.wr_data    (pmem_addr_ff),
		.rd_data_ff (stk_top)
	);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff  <= 8'h00;
			pin_s2_ff  <= 8'h00;
			wake_s1_ff <= 1'b0;
			wake_s2_ff <= 1'b0;
		end else begin
			pin_s1_ff  <= port_pins;
			pin_s2_ff  <= pin_s1_ff;
			wake_s1_ff <= wake_pin;
			wake_s2_ff <= wake_s1_ff;
		end
	end

	// ****************************************
	// Execute
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff         <= `RID_PH_ADDR;
			ir_ff         <= `RID_W_NOP;
			pmem_addr_ff  <= 11'h000;
			file_addr_ff  <= 7'h00;
			file_wdata_ff <= 8'h00;
			file_we_ff    <= 1'b0;
			acc_ff        <= 8'h00;
			status_ff     <= `RID_ST_RST;
			presc_clr_ff  <= 1'b0;
			sleep_ff      <= 1'b0;
			wdt_clr_ff    <= 1'b0;
		end else begin
			file_we_ff   <= 1'b0;
			presc_clr_ff <= 1'b0;
			wdt_clr_ff   <= 1'b0;
			if (sleep_ff && wake_s2_ff) begin
				sleep_ff <= 1'b0;
			end
			if (step) begin
				ph_ff <= ph_ff + 2'h1;
				if (ph_ff == `RID_PH_ADDR) begin
					file_addr_ff <= ir_ff[6:0];
				end
			end
			if (exec) begin
				if (nxt_to_acc) begin
					acc_ff <= nxt_res;
				end
				if (nxt_to_file) begin
					file_we_ff    <= 1'b1;
					file_wdata_ff <= nxt_res;
					// Prescaler restarts on any timer-zero write when assigned to it
					presc_clr_ff  <= (ir_ff[6:0] == `RID_TIMER0_ADDR) & ctrl_ff[`RID_CTRL_PSA]; // [RL15]
				end
				if (nxt_z_upd) begin
					status_ff[`RID_ST_Z] <= (nxt_res == 8'h00); // [RL10]
				end
				if (nxt_c_upd) begin
					status_ff[`RID_ST_C] <= nxt_c;
				end
				if (nxt_dc_upd) begin
					status_ff[`RID_ST_DC] <= nxt_dc;
				end
				if (nxt_sleep) begin
					status_ff[`RID_ST_TO] <= 1'b1; // [RL13]
					status_ff[`RID_ST_PWRDN] <= 1'b0;
					sleep_ff              <= 1'b1;
				end
				if (nxt_wdt) begin
					status_ff[`RID_ST_TO] <= 1'b1;
					status_ff[`RID_ST_PWRDN] <= 1'b1;
					wdt_clr_ff            <= 1'b1;
				end
				// Taken branch or true test: drop the prefetched word
				if (nxt_jump || nxt_skip) begin
					ir_ff <= `RID_W_NOP; // [RL16] [RL17]
				end else begin
					ir_ff <= pmem_data;
				end
				pmem_addr_ff <= nxt_jump ? nxt_target : pmem_addr_ff + 11'h001; // [RL16]
			end
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// Answer one cycle after the request is seen; stalls the master once
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff            <= `RID_CTRL_RST;
			avs_waitrequest_ff <= 1'b1;
			avs_readdata_ff    <= 32'h00000000;
		end else begin
			avs_waitrequest_ff <= 1'b1;
			if ((avs_read || avs_write) && avs_waitrequest_ff) begin
				avs_waitrequest_ff <= 1'b0;
				if (avs_address == `RID_REG_CTRL) begin
					avs_readdata_ff <= {30'h0, ctrl_ff};
				end else if (avs_address == `RID_REG_ACC) begin
					avs_readdata_ff <= {24'h000000, acc_ff};
				end else if (avs_address == `RID_REG_STATUS) begin
					avs_readdata_ff <= {27'h0, status_ff};
				end else if (avs_address == `RID_REG_PC) begin
					avs_readdata_ff <= {21'h0, pmem_addr_ff};
				end else if (avs_address == `RID_REG_IR) begin
					avs_readdata_ff <= {18'h0, ir_ff};
				end else begin
					avs_readdata_ff <= 32'h00000000;
				end
			end
			if (avs_write && !avs_waitrequest_ff && avs_address == `RID_REG_CTRL) begin
				ctrl_ff <= avs_writedata[1:0];
			end
		end
	end

endmodule

// File: logic/rid_defines.vh
// Purpose: Constants for the 14-bit instruction decoder and its register slave
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
//
// Overview of operation
// RL1: OR, AND, XOR with file: one cycle, zero only
// RL2: File XOR: one cycle, zero flag only
// RL3: Decrement file, skip on zero, no flags
// RL4: Increment file, skip on zero, no flags
// RL5: Rotate file left through carry, carry only
// RL6: Rotate file right through carry, carry only
// RL7: Bit test skips when bit clear
// RL8: Bit test skips when bit set
// RL9: Literal OR, AND, XOR into accumulator, zero
// RL10: Literal XOR result to accumulator, zero updated
// RL11: Literal subtract and add update C, DC, Z
// RL12: Literal load with return, two cycles
// RL13: Standby word sets timeout, clears powerdown flag
// RL14: Port read-modify-write reads pin levels
// RL15: Timer zero write clears assigned prescaler
// RL16: Branch or true test takes two cycles
// RL17: Fetched word discarded, second cycle is NOP
// RL18: Bit clear op: one cycle, no flags
// RL19: Bit set op: one cycle, no flags
// RL20: Call pushes return address, jump does not
// RL21: Destination bit selects accumulator or file
// RL22: File add and subtract update C, DC, Z
`ifndef RID_DEFINES_VH
`define RID_DEFINES_VH

// ****************************************
// Instruction cycle
// ****************************************
`define RID_PH_W        2
`define RID_PH_ADDR     2'h0
`define RID_PH_LAST     2'h3

// ****************************************
// Special file addresses
// ****************************************
`define RID_TIMER0_ADDR 7'h01
`define RID_PORT_B_ADDR 7'h06

// ****************************************
// Instruction classes and byte, bit and literal opcodes
// ****************************************
`define RID_CL_BYTE     2'h0
`define RID_CL_BIT      2'h1
`define RID_CL_CTL      2'h2
`define RID_CL_LIT      2'h3
`define RID_OP_MISC     4'h0
`define RID_OP_CLR      4'h1
`define RID_OP_SUB      4'h2
`define RID_OP_DEC      4'h3
`define RID_OP_IOR      4'h4
`define RID_OP_AND      4'h5
`define RID_OP_XOR      4'h6
`define RID_OP_ADD      4'h7
`define RID_OP_MOV      4'h8
`define RID_OP_COM      4'h9
`define RID_OP_INC      4'hA
`define RID_OP_DECSZ    4'hB
`define RID_OP_RRC      4'hC
`define RID_OP_RLC      4'hD
`define RID_OP_SWAP     4'hE
`define RID_OP_INCSZ    4'hF
`define RID_BIT_CLR     2'h0
`define RID_BIT_SET     2'h1
`define RID_BIT_TSC     2'h2
`define RID_BIT_TSS     2'h3
`define RID_LIT_MOV     2'h0
`define RID_LIT_RET     2'h1
`define RID_LIT_IOR     4'h8
`define RID_LIT_AND     4'h9
`define RID_LIT_XOR     4'hA
`define RID_LIT_SUB     3'h6
`define RID_LIT_ADD     3'h7

// ****************************************
// Fixed words
// ****************************************
`define RID_W_NOP       14'h0000
`define RID_W_RET       14'h0008
`define RID_W_RETI      14'h0009
`define RID_W_SLEEP     14'h0063
`define RID_W_CLRWDT    14'h0064

// ****************************************
// Status and control layout, reset values and stack depth
// ****************************************
`define RID_ST_C        0
`define RID_ST_DC       1
`define RID_ST_Z        2
`define RID_ST_PWRDN    3
`define RID_ST_TO       4
`define RID_ST_RST      5'h18
`define RID_CTRL_RST    2'h1
`define RID_CTRL_RUN    0
`define RID_CTRL_PSA    1
`define RID_STK_DEPTH   8

// ****************************************
// Register map, byte addresses
// ****************************************
`define RID_REG_CTRL    5'h00
`define RID_REG_ACC     5'h04
`define RID_REG_STATUS  5'h08
`define RID_REG_PC      5'h0C
`define RID_REG_IR      5'h10

`endif

// File: logic/rid_stack.v
// Purpose: Return address stack with registered read data
// Assumes: Push and pop never in the same cycle
// Notes:   Pointer wraps; overflow silently overwrites the oldest entry
`timescale 1ns/1ns
`include "rid_defines.vh"

module rid_stack (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Stack access
	input  wire        push,
	input  wire        pop,
	input  wire [10:0] wr_data,
	output reg  [10:0] rd_data_ff
);

	reg [10:0] mem [0:`RID_STK_DEPTH-1];
	reg [2:0]  sp_ff;

	always @(posedge ref_clk) begin
		if (push) begin
			mem[sp_ff] <= wr_data;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_ff      <= 3'h0;
			rd_data_ff <= 11'h000;
		end else begin
			if (push) begin
				sp_ff <= sp_ff + 3'h1;
			end else if (pop) begin
				sp_ff <= sp_ff - 3'h1;
			end
			// Top of stack always ready one cycle ahead of the pop
			rd_data_ff <= mem[sp_ff - 3'h1];
		end
	end

endmodule

// File: dv/rid_core_properties.sv
// Purpose: Port-level checks on the instruction decoder core
// Assumes: One clock, reset asynchronous and active low
// Notes:   Bound to every rid_core instance
`timescale 1ns/1ns

module rid_core_properties (
	// Clock and reset
	input logic        ref_clk,
	input logic        rst_n,
	// Register bus
	input logic [4:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_readdata_ff,
	input logic        avs_waitrequest_ff,
	// Core side
	input logic [10:0] pmem_addr_ff,
	input logic [6:0]  file_addr_ff,
	input logic        file_we_ff,
	input logic        presc_clr_ff,
	input logic        sleep_ff,
	input logic        wdt_clr_ff,
	input logic [7:0]  acc_ff,
	input logic [4:0]  status_ff
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic mapped;
	assign mapped = avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};

	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest_ff |=> !avs_waitrequest_ff)
		else $error("bus request not answered next cycle");
	a_wait_pulse: assert property (!avs_waitrequest_ff |=> avs_waitrequest_ff)
		else $error("waitrequest low for more than one cycle");
	a_unmapped_zero: assert property (!avs_waitrequest_ff && avs_read && !mapped |-> avs_readdata_ff == 32'h0)
		else $error("unmapped read returned nonzero");
	a_pc_spacing: assert property ($changed(pmem_addr_ff) |=> $stable(pmem_addr_ff) [*3])
		else $error("program address moved inside an instruction cycle");
	a_acc_spacing: assert property ($changed(acc_ff) |=> $stable(acc_ff) [*3])
		else $error("accumulator moved inside an instruction cycle");
	a_we_single: assert property (file_we_ff |=> !file_we_ff [*3])
		else $error("more than one file write per instruction cycle");
	a_presc_cause: assert property (presc_clr_ff |->
		file_we_ff && (file_addr_ff == 7'h01 || $past(file_addr_ff) == 7'h01))
		else $error("prescaler clear without timer write");
	a_sleep_flags: assert property ($rose(sleep_ff) |-> status_ff[4:3] == 2'h2)
		else $error("standby entered with wrong power flags");
	a_flags_cause: assert property ($changed(status_ff[4:3]) |-> ##[0:1] (sleep_ff || wdt_clr_ff))
		else $error("power flags changed without standby or watchdog word");
	a_sleep_frozen: assert property (sleep_ff && $past(sleep_ff) |-> $stable(pmem_addr_ff) && $stable(acc_ff))
		else $error("core advanced while in standby");
endmodule

bind rid_core rid_core_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata_ff(avs_readdata_ff),
	.avs_waitrequest_ff(avs_waitrequest_ff), .pmem_addr_ff(pmem_addr_ff), .file_addr_ff(file_addr_ff),
	.file_we_ff(file_we_ff), .presc_clr_ff(presc_clr_ff), .sleep_ff(sleep_ff), .wdt_clr_ff(wdt_clr_ff),
	.acc_ff(acc_ff), .status_ff(status_ff));

// File: dv/rid_mem_model.sv
// Purpose: Program memory and data file space seen by the core
// Assumes: Bench preloads both arrays by hierarchical access
// Notes:   Reads registered, the slowest the core contract allows
`timescale 1ns/1ns

module rid_mem_model (
	// Clock
	input  wire        ref_clk,
	// Program side
	input  wire [10:0] pmem_addr,
	output reg  [13:0] pmem_data,
	// File side
	input  wire [6:0]  file_addr,
	input  wire [7:0]  file_wdata,
	input  wire        file_we,
	output reg  [7:0]  file_rdata
);
	logic [13:0] prog [0:2047];
	logic [7:0]  file [0:127];

	initial begin
		for (int i = 0; i < 2048; i++) prog[i] = 14'h0000;
		for (int i = 0; i < 128; i++) file[i] = 8'h00;
	end

	always @(posedge ref_clk) begin
		pmem_data <= prog[pmem_addr];
		file_rdata <= file[file_addr];
		if (file_we)
			file[file_addr] <= file_wdata;
	end
endmodule

// File: dv/risc14_instruction_decoder_tb_top.sv
// Purpose: Self-checking bench for the instruction decoder core
// Assumes: Programs preloaded while the core is held in reset
// Notes:   Results seen on acc, status, file contents and the bus
`timescale 1ns/1ns
`include "rid_defines.vh"

module risc14_instruction_decoder_tb_top;
	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata_ff;
	logic        avs_waitrequest_ff;
	logic [10:0] pmem_addr_ff;
	logic [13:0] pmem_data;
	logic [6:0]  file_addr_ff;
	logic [7:0]  file_wdata_ff;
	logic        file_we_ff;
	logic [7:0]  file_rdata;
	logic [7:0]  port_pins = 8'hA5;
	logic        wake_pin = 1'h0;
	logic        presc_clr_ff;
	logic        sleep_ff;
	logic        wdt_clr_ff;
	logic [7:0]  acc_ff;
	logic [4:0]  status_ff;
	logic [13:0] pw [$];
	logic [6:0]  fa [$];
	logic [7:0]  fe [$];
	logic [31:0] rd;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          n_presc = 0;
	int          n_wdt = 0;

	rid_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
		.avs_waitrequest_ff(avs_waitrequest_ff), .pmem_addr_ff(pmem_addr_ff), .pmem_data(pmem_data),
		.file_addr_ff(file_addr_ff), .file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff),
		.file_rdata(file_rdata), .port_pins(port_pins), .wake_pin(wake_pin), .presc_clr_ff(presc_clr_ff),
		.sleep_ff(sleep_ff), .wdt_clr_ff(wdt_clr_ff), .acc_ff(acc_ff), .status_ff(status_ff));
	rid_mem_model mem (.ref_clk(ref_clk), .pmem_addr(pmem_addr_ff), .pmem_data(pmem_data),
		.file_addr(file_addr_ff), .file_wdata(file_wdata_ff), .file_we(file_we_ff), .file_rdata(file_rdata));

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (presc_clr_ff === 1'h1) n_presc++;
	always @(posedge ref_clk) if (wdt_clr_ff === 1'h1) n_wdt++;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'h1;
		do @(posedge ref_clk); while (avs_waitrequest_ff !== 1'h0);
		avs_write <= 1'h0;
		// Idle edge so a following call never re-raises the strobe in the same step
		@(posedge ref_clk);
	endtask

	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'h1;
		do @(posedge ref_clk); while (avs_waitrequest_ff !== 1'h0);
		d = avs_readdata_ff;
		avs_read <= 1'h0;
		@(posedge ref_clk);
	endtask

	// Reload program under reset so no fetch sees a half-written image
	task automatic run(input logic presc);
		rst_n <= 1'h0;
		@(posedge ref_clk);
		for (int i = 0; i < 32; i++) mem.prog[i] = (i < pw.size()) ? pw[i] : 14'h0000;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		if (presc)
			bus_wr(`RID_REG_CTRL, 32'h3);
	endtask

	// Halt word jumps to itself: address must alternate every 4 clocks
	task automatic wait_addr(input logic [10:0] stop);
		int n;
		do @(posedge ref_clk); while (pmem_addr_ff !== stop);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pmem_addr_ff === stop);
		do begin
			@(posedge ref_clk);
			n++;
		end while (pmem_addr_ff !== stop);
		check("halt loop clocks", n, 8);
	endtask

	task automatic check_files;
		foreach (fa[i]) check("file", mem.file[fa[i]], fe[i]);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		pw = '{14'h300F, 14'h38F0, 14'h00A0, 14'h393C, 14'h00A1, 14'h3A3C, 14'h00A2, 14'h3E88, 14'h3F88,
			14'h00A3, 14'h3D05, 14'h00A4, 14'h06A3, 14'h0420, 14'h0521, 14'h00A5, 14'h07A2, 14'h0221, 14'h2812};
		run(1'h0);
		wait_addr(11'h013);
		check("acc", acc_ff, 8'h00);
		check("status", status_ff, 5'h1F);
		fa = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25};
		fe = '{8'hFF, 8'h3C, 8'h3C, 8'hE5, 8'hF5, 8'h3C};
		check_files();
		bus_rd(`RID_REG_STATUS, rd);
		check("status reg", rd, 32'h1F);
		bus_rd(`RID_REG_CTRL, rd);
		check("ctrl reg", rd, 32'h1);
		bus_wr(`RID_REG_ACC, 32'hAB);
		bus_rd(5'h14, rd);
		check("unmapped", rd, 32'h0);
		bus_rd(`RID_REG_ACC, rd);
		check("acc reg", rd, 32'h0);
		bus_wr(`RID_REG_CTRL, 32'h0);
		bus_rd(`RID_REG_CTRL, rd);
		check("ctrl stop", rd, 32'h0);
		$display("test literal and byte ops done");

		pw = '{14'h3001, 14'h00B0, 14'h0BB0, 14'h30EE, 14'h0FB0, 14'h0081, 14'h17B1, 14'h1FB1, 14'h30EE,
			14'h1831, 14'h30EE, 14'h11B1, 14'h0DB1, 14'h0C31, 14'h00B2, 14'h0886, 14'h2014, 14'h00B3,
			14'h2812, 14'h0000, 14'h345A};
		for (int k = 0; k < 2; k++) begin
			mem.file[7'h31] = 8'h0A;
			mem.file[7'h06] = 8'hFF;
			n_presc = 0;
			run(k[0]);
			wait_addr(11'h013);
			check("prescaler clears", n_presc, k);
		end
		check("acc", acc_ff, 8'h5A);
		check("status", status_ff, 5'h18);
		fa = '{7'h30, 7'h31, 7'h32, 7'h33, 7'h06};
		fe = '{8'h01, 8'h04, 8'h82, 8'h5A, 8'hA5};
		check_files();
		$display("test skips, bits and calls done");

		pw = '{14'h0063, 14'h0064, 14'h3077, 14'h2803};
		run(1'h0);
		do @(posedge ref_clk); while (sleep_ff !== 1'h1);
		repeat (12) @(posedge ref_clk);
		check("asleep", sleep_ff, 1'h1);
		check("flags asleep", status_ff[4:3], 2'h2);
		check("acc asleep", acc_ff, 8'h00);
		wake_pin <= 1'h1;
		wait_addr(11'h004);
		wake_pin <= 1'h0;
		check("acc woken", acc_ff, 8'h77);
		check("flags woken", status_ff[4:3], 2'h3);
		check("watchdog clears", n_wdt, 1);
		$display("test standby done");
		close_out();
	end

	// Whole run is a few hundred clocks; this is about fifty times that
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
endmodule
